//--- bcd_chain.sv
// Loadable BCD up-counter chain, wrapping modulo ten to the number of digits.
module bcd_chain #(
    parameter int DIGITS = freq_counter_pkg::NUM_DIGITS
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_b,
    // Control
    input wire logic i_load,
    input wire logic [DIGITS*freq_counter_pkg::BCD_W-1:0] i_preset,
    input wire logic i_inc,
    // Count
    output logic [DIGITS*freq_counter_pkg::BCD_W-1:0] o_count
);
    localparam int W = freq_counter_pkg::BCD_W;

    logic [DIGITS-1:0] carry;

    assign carry[0] = i_inc & ~i_load;

    //==========================================================================
    // Digit chain
    for (genvar g = 0; g < DIGITS; g++) begin : gen_digit
        logic [W-1:0] dig_ff;
        logic [W-1:0] nxt_dig;
        always_comb begin
            nxt_dig = dig_ff;
            if (i_load) begin
                nxt_dig = i_preset[g*W +: W];
            end else if (carry[g]) begin
                // The top digit wraps too, so the MHz pair rolls modulo one hundred.
                nxt_dig = (dig_ff == freq_counter_pkg::BCD_NINE) ?
                    freq_counter_pkg::BCD_ZERO : dig_ff + freq_counter_pkg::BCD_ONE;
            end
        end
        always_ff @(posedge i_mclk or negedge i_rst_b) begin
            if (!i_rst_b) begin
                dig_ff <= freq_counter_pkg::BCD_ZERO;
            end else begin
                dig_ff <= nxt_dig;
            end
        end
        if (g + 1 < DIGITS) begin : gen_carry
            assign carry[g+1] = carry[g] & (dig_ff == freq_counter_pkg::BCD_NINE);
        end
        assign o_count[g*W +: W] = dig_ff;
    end

    //==========================================================================
    // Checks
    chk_bcd_load: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        i_load |=> o_count == $past(i_preset))
        else $error("counter did not take the preset");

endmodule

//--- freq_counter_pkg.sv
// Shared constants and types for the preset frequency counter and display.
package freq_counter_pkg;

    //==========================================================================
    // Clock and timing
    localparam int CLK_HZ = 50_000_000;
    localparam int XTAL_DIV_LOG2 = 20;
    localparam int PRESCALE_RATIO = 10;
    localparam int LOAD_MS = 5;
    localparam int STORE_US = 50;
    localparam int SCAN_HZ = 2500;
    localparam int NUM_DIGITS = 6;
    localparam int LOAD_CYC = CLK_HZ / 1000 * LOAD_MS;
    localparam int STORE_CYC = CLK_HZ / 1_000_000 * STORE_US;
    localparam int DIGIT_CYC = CLK_HZ / (SCAN_HZ * NUM_DIGITS);

    //==========================================================================
    // Digits and presets
    localparam int BCD_W = 4;
    localparam logic [3:0] BCD_ZERO = 4'h0;
    localparam logic [3:0] BCD_ONE = 4'h1;
    localparam logic [3:0] BCD_NINE = 4'h9;
    localparam logic [23:0] PRESET_LOW_BANDS = 24'h910000;
    localparam logic [23:0] PRESET_OTHER_BANDS = 24'h090000;

    //==========================================================================
    // Pin synchroniser layout
    localparam int SYNC_W = 7;
    localparam int PIN_OSC = 0;
    localparam int PIN_XTAL = 1;
    localparam int PIN_PRST = 2;
    localparam int PIN_PROG = 3;
    localparam int PROG_FIRST = 0;
    localparam int PROG_FOURTH = 3;

    //==========================================================================
    // Display coding, segments in order g f e d c b a, high means lit
    localparam logic [5:0] DIGIT_EN_RST = 6'h01;
    localparam logic [6:0] SEG_BLANK = 7'h00;
    localparam logic [6:0] SEG_TABLE [0:9] = '{
        7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f
    };

    typedef enum logic [0:0] {
        PH_XFER = 1'b0,
        PH_COUNT = 1'b1
    } gate_phase_t;

endpackage

//--- osc_display_model.sv
// Behavioural tuning oscillator, crystal reference and six-digit display reader.
module osc_display_model #(
    parameter int XTAL_HALF_NS = 200
) (
    // Clock
    input wire logic i_mclk,
    // Oscillator control
    input wire logic i_slow,
    // Source pins
    output logic o_osc,
    output logic o_xtal_ref,
    // Display pins
    input wire logic [6:0] i_seg,
    input wire logic [5:0] i_digit_en,
    // Value read off the display
    output logic [23:0] o_shown
);
    timeunit 1ns;
    timeprecision 1ns;

    //==========
    // Sources
    // Every edge lands 5 ns before a clock rise, so sampling never depends on jitter.
    initial begin
        o_osc = 1'b0;
        #25;
        forever begin
            #(i_slow ? 80 : 40);
            o_osc = ~o_osc;
        end
    end

    initial begin
        o_xtal_ref = 1'b0;
        #5;
        forever begin
            #(XTAL_HALF_NS);
            o_xtal_ref = ~o_xtal_ref;
        end
    end

    //==========
    // Display reader
    // An unknown segment pattern reads as 4'hf, so a bad decode cannot hide behind an old digit.
    initial o_shown = 24'h000000;
    always @(posedge i_mclk) begin
        logic [3:0] dv;
        for (int d = 0; d < 6; d++) begin
            if (i_digit_en === (6'h01 << d)) begin
                dv = 4'hf;
                for (int v = 0; v < 10; v++) begin
                    if (i_seg === freq_counter_pkg::SEG_TABLE[v]) begin
                        dv = 4'(v);
                    end
                end
                o_shown[4*d +: 4] <= dv;
            end
        end
    end
endmodule

//--- prescale_div10.sv
// Decade prescaler: one tick for every ten accepted input edges, held while reset.
module prescale_div10 #(
    parameter int RATIO = freq_counter_pkg::PRESCALE_RATIO
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_b,
    // Edge input and hold
    input wire logic i_edge,
    input wire logic i_hold,
    // Divided output
    output logic o_tick
);
    localparam int CW = $clog2(RATIO);
    localparam logic [CW-1:0] LAST = CW'(RATIO - 1);

    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic tick_ff;
    logic nxt_tick;
    logic [CW:0] h_edges;

    //==========================================================================
    // Divider
    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_tick = 1'b0;
        if (i_hold) begin
            nxt_cnt = '0;
        end else if (i_edge) begin
            if (cnt_ff == LAST) begin
                nxt_cnt = '0;
                nxt_tick = 1'b1;
            end else begin
                nxt_cnt = cnt_ff + CW'(1);
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_ff <= '0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign o_tick = tick_ff;

    //==========================================================================
    // Checks
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            h_edges <= '0;
        end else if (i_hold) begin
            h_edges <= '0;
        end else if (tick_ff) begin
            h_edges <= {{CW{1'b0}}, i_edge};
        end else if (i_edge) begin
            h_edges <= h_edges + (CW + 1)'(1);
        end
    end

    chk_prescale_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        i_hold |=> !o_tick)
        else $error("prescaler ticked while held");
    chk_prescale_ratio: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        o_tick |-> h_edges == (CW + 1)'(RATIO))
        else $error("prescaler tick not after ten edges");

endmodule

//--- preset_frequency_counter_display.sv
// Top level: prescaled frequency counter with band preset and six-digit multiplexed readout.
//==============================================================================
module preset_frequency_counter_display #(
    parameter int LOAD_CYCLES = freq_counter_pkg::LOAD_CYC,
    parameter int STORE_CYCLES = freq_counter_pkg::STORE_CYC,
    parameter int DIGIT_CYCLES = freq_counter_pkg::DIGIT_CYC,
    parameter int XTAL_DIV_LOG2 = freq_counter_pkg::XTAL_DIV_LOG2
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_b,
    // Oscillator and time base pins
    input wire logic i_osc,
    input wire logic i_xtal_ref,
    input wire logic i_prescale_rst,
    // Band program lines
    input wire logic [3:0] i_prog,
    // Timing outputs
    output logic o_gate,
    output logic o_load,
    output logic o_store_b,
    // Display drive
    output logic [6:0] o_seg,
    output logic [5:0] o_digit_en
);
    localparam int ND = freq_counter_pkg::NUM_DIGITS;
    localparam int CNT_W = ND * freq_counter_pkg::BCD_W;
    localparam int SW = freq_counter_pkg::SYNC_W;
    localparam int HALF_W = XTAL_DIV_LOG2 - 1;
    localparam int STORE_W = $clog2(STORE_CYCLES + 1);
    localparam int LOAD_W = $clog2(LOAD_CYCLES + 1);
    localparam int DWELL_W = $clog2(DIGIT_CYCLES + 1);
    localparam int IDX_W = $clog2(ND);
    localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(ND - 1);

    //==========================================================================
    // Pin synchronisers
    // Three stages per pin; a high level is accepted only when stages two and three agree, and the level drops as soon as they differ.
    logic [SW-1:0] pins;
    logic [SW-1:0] s1_ff;
    logic [SW-1:0] s2_ff;
    logic [SW-1:0] s3_ff;
    logic [SW-1:0] lvl_ff;
    logic [SW-1:0] nxt_lvl;
    logic [SW-1:0] rise;

    assign pins = {i_prog, i_prescale_rst, i_xtal_ref, i_osc};

    always_comb begin
        nxt_lvl = (s2_ff & s3_ff) | (lvl_ff & ~(s2_ff ^ s3_ff));
        rise = nxt_lvl & ~lvl_ff;
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            lvl_ff <= '0;
        end else begin
            s1_ff <= pins;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            lvl_ff <= nxt_lvl;
        end
    end

    //==========================================================================
    // Prescaler
    // The oscillator is sampled, not clocked in, so inputs near half the
    // system clock may lose edges; the filter trades bandwidth for glitch immunity.
    logic presc_tick;

    prescale_div10 u_prescale (
        .i_mclk(i_mclk),
        .i_rst_b(i_rst_b),
        .i_edge(rise[freq_counter_pkg::PIN_OSC]),
        .i_hold(lvl_ff[freq_counter_pkg::PIN_PRST]),
        .o_tick(presc_tick)
    );

    //==========================================================================
    // Gate time base
    freq_counter_pkg::gate_phase_t phase_ff;
    freq_counter_pkg::gate_phase_t nxt_phase;
    logic [HALF_W-1:0] ref_cnt_ff;
    logic [HALF_W-1:0] nxt_ref_cnt;
    logic xfer_start;

    always_comb begin
        nxt_ref_cnt = ref_cnt_ff;
        nxt_phase = phase_ff;
        if (rise[freq_counter_pkg::PIN_XTAL]) begin
            nxt_ref_cnt = ref_cnt_ff + HALF_W'(1);
            if (ref_cnt_ff == '1) begin
                // Toggle every half of the full power-of-two division.
                nxt_phase = (phase_ff == freq_counter_pkg::PH_COUNT) ?
                    freq_counter_pkg::PH_XFER : freq_counter_pkg::PH_COUNT;
            end
        end
        xfer_start = (phase_ff == freq_counter_pkg::PH_COUNT) &&
            (nxt_phase == freq_counter_pkg::PH_XFER);
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ref_cnt_ff <= '0;
            phase_ff <= freq_counter_pkg::PH_COUNT;
        end else begin
            ref_cnt_ff <= nxt_ref_cnt;
            phase_ff <= nxt_phase;
        end
    end

    assign o_gate = phase_ff;

    //==========================================================================
    // Store and load one-shots
    logic store_b_ff;
    logic nxt_store_b;
    logic [STORE_W-1:0] store_cnt_ff;
    logic [STORE_W-1:0] nxt_store_cnt;
    logic load_ff;
    logic nxt_load;
    logic [LOAD_W-1:0] load_cnt_ff;
    logic [LOAD_W-1:0] nxt_load_cnt;

    always_comb begin
        nxt_store_b = store_b_ff;
        nxt_store_cnt = store_cnt_ff;
        nxt_load = load_ff;
        nxt_load_cnt = load_cnt_ff;
        if (xfer_start) begin
            nxt_store_b = 1'b0;
            nxt_store_cnt = STORE_W'(STORE_CYCLES - 1);
            nxt_load = 1'b1;
            nxt_load_cnt = LOAD_W'(LOAD_CYCLES - 1);
        end else begin
            if (!store_b_ff) begin
                if (store_cnt_ff == '0) begin
                    nxt_store_b = 1'b1;
                end else begin
                    nxt_store_cnt = store_cnt_ff - STORE_W'(1);
                end
            end
            if (load_ff) begin
                if (load_cnt_ff == '0) begin
                    nxt_load = 1'b0;
                end else begin
                    nxt_load_cnt = load_cnt_ff - LOAD_W'(1);
                end
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            store_b_ff <= 1'b1;
            store_cnt_ff <= '0;
            load_ff <= 1'b0;
            load_cnt_ff <= '0;
        end else begin
            store_b_ff <= nxt_store_b;
            store_cnt_ff <= nxt_store_cnt;
            load_ff <= nxt_load;
            load_cnt_ff <= nxt_load_cnt;
        end
    end

    assign o_store_b = store_b_ff;
    assign o_load = load_ff;

    //==========================================================================
    // Counter, preset and display latch
    logic band_low;
    logic [CNT_W-1:0] preset;
    logic [CNT_W-1:0] count;
    logic cnt_inc;
    logic [CNT_W-1:0] latch_ff;
    logic [CNT_W-1:0] nxt_latch;

    always_comb begin
        // Only the first and fourth lines carry band information.
        band_low = lvl_ff[freq_counter_pkg::PIN_PROG + freq_counter_pkg::PROG_FIRST] &
            lvl_ff[freq_counter_pkg::PIN_PROG + freq_counter_pkg::PROG_FOURTH];
        preset = band_low ? freq_counter_pkg::PRESET_LOW_BANDS :
            freq_counter_pkg::PRESET_OTHER_BANDS;
        cnt_inc = presc_tick && (phase_ff == freq_counter_pkg::PH_COUNT);
        nxt_latch = xfer_start ? count : latch_ff;
    end

    bcd_chain u_count (
        .i_mclk(i_mclk),
        .i_rst_b(i_rst_b),
        .i_load(load_ff),
        .i_preset(preset),
        .i_inc(cnt_inc),
        .o_count(count)
    );

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            latch_ff <= '0;
        end else begin
            latch_ff <= nxt_latch;
        end
    end

    //==========================================================================
    // Display multiplexer
    logic [DWELL_W-1:0] dwell_ff;
    logic [DWELL_W-1:0] nxt_dwell;
    logic [IDX_W-1:0] idx_ff;
    logic [IDX_W-1:0] nxt_idx;
    logic [ND-1:0] digit_en_ff;
    logic [ND-1:0] nxt_digit_en;
    logic [6:0] seg_ff;
    logic [6:0] nxt_seg;

    function automatic logic [6:0] seg_of(input logic [3:0] d);
        seg_of = (d <= freq_counter_pkg::BCD_NINE) ? freq_counter_pkg::SEG_TABLE[d] :
            freq_counter_pkg::SEG_BLANK;
    endfunction

    always_comb begin
        nxt_dwell = dwell_ff - DWELL_W'(1);
        nxt_idx = idx_ff;
        nxt_digit_en = digit_en_ff;
        nxt_seg = seg_ff;
        if (dwell_ff == '0) begin
            nxt_dwell = DWELL_W'(DIGIT_CYCLES - 1);
            nxt_idx = (idx_ff == IDX_LAST) ? '0 : idx_ff + IDX_W'(1);
            nxt_digit_en = {digit_en_ff[ND-2:0], digit_en_ff[ND-1]};
            nxt_seg = seg_of(latch_ff[nxt_idx*freq_counter_pkg::BCD_W +: 4]);
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            dwell_ff <= '0;
            idx_ff <= IDX_LAST;
            // Parked one step behind digit zero, so the first step lights digit zero.
            digit_en_ff <= {freq_counter_pkg::DIGIT_EN_RST[0],
                freq_counter_pkg::DIGIT_EN_RST[ND-1:1]};
            seg_ff <= freq_counter_pkg::SEG_BLANK;
        end else begin
            dwell_ff <= nxt_dwell;
            idx_ff <= nxt_idx;
            digit_en_ff <= nxt_digit_en;
            seg_ff <= nxt_seg;
        end
    end

    assign o_digit_en = digit_en_ff;
    assign o_seg = seg_ff;

    //==========================================================================
    // Checks
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_b);

    int h_store_len;
    int h_load_len;
    int h_ref_edges;
    logic h_gate_prev;

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            h_store_len <= 0;
            h_load_len <= 0;
            h_ref_edges <= 0;
            h_gate_prev <= 1'b1;
        end else begin
            h_store_len <= o_store_b ? 0 : h_store_len + 1;
            h_load_len <= o_load ? h_load_len + 1 : 0;
            h_gate_prev <= o_gate;
            if (o_gate != h_gate_prev) begin
                h_ref_edges <= rise[freq_counter_pkg::PIN_XTAL] ? 1 : 0;
            end else if (rise[freq_counter_pkg::PIN_XTAL]) begin
                h_ref_edges <= h_ref_edges + 1;
            end
        end
    end

    sequence seq_xfer_start;
        $fell(o_gate);
    endsequence

    sequence seq_digit_step;
        $changed(o_digit_en);
    endsequence

    chk_gate_half_period: assert property ($changed(o_gate) |->
        h_ref_edges == 2 ** HALF_W)
        else $error("gate half period is not the divided reference");
    chk_count_window: assert property ((!o_gate && !o_load) |=>
        count == $past(count))
        else $error("counter moved outside the counting window");
    chk_pulse_trigger: assert property (seq_xfer_start |->
        $fell(o_store_b) && $rose(o_load))
        else $error("store and load did not start at the gate");
    chk_store_width: assert property ($rose(o_store_b) |->
        h_store_len == STORE_CYCLES)
        else $error("store pulse width wrong");
    chk_load_width: assert property ($fell(o_load) |->
        h_load_len == LOAD_CYCLES)
        else $error("load pulse width wrong");
    chk_latch_take: assert property (seq_xfer_start |->
        latch_ff == $past(count))
        else $error("latch did not take the final count");
    chk_preset_value: assert property ($fell(o_load) |->
        count == $past(preset))
        else $error("counter not at band preset after load");
    chk_digit_onehot: assert property ($onehot(o_digit_en))
        else $error("digit enables not one-hot");
    chk_digit_dwell: assert property (seq_digit_step |=>
        $stable(o_digit_en) [*8])
        else $error("digit dwell too short");
    chk_digit_order: assert property (seq_digit_step |->
        o_digit_en == {$past(o_digit_en[ND-2:0]), $past(o_digit_en[ND-1])})
        else $error("digits not scanned in order");
    chk_seg_decode: assert property (seq_digit_step |->
        o_seg == seg_of($past(latch_ff[nxt_idx*freq_counter_pkg::BCD_W +: 4])))
        else $error("segments do not match the enabled digit");

endmodule

//--- preset_frequency_counter_display_tb.sv
// Self-checking bench for the preset frequency counter and its multiplexed readout.
module preset_frequency_counter_display_tb;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int XLOG = 6;
    localparam int LOADC = 40;
    localparam int STOREC = 10;
    localparam int DIGC = 12;
    localparam int XTAL_CLKS = 20;
    localparam int HALF = (1 << (XLOG - 1)) * XTAL_CLKS;

    logic i_mclk;
    logic i_rst_b;
    logic i_prescale_rst;
    logic [3:0] i_prog;
    logic slow;
    logic osc;
    logic xtal;
    logic o_gate;
    logic o_load;
    logic o_store_b;
    logic [6:0] o_seg;
    logic [5:0] o_digit_en;
    logic [23:0] shown;
    logic [23:0] exp_q[$];
    logic [31:0] rnd;
    int bad_count;
    int num_checks;

    preset_frequency_counter_display #(
        .LOAD_CYCLES(LOADC),
        .STORE_CYCLES(STOREC),
        .DIGIT_CYCLES(DIGC),
        .XTAL_DIV_LOG2(XLOG)
    ) preset_frequency_counter_display_inst (
        .i_mclk(i_mclk),
        .i_rst_b(i_rst_b),
        .i_osc(osc),
        .i_xtal_ref(xtal),
        .i_prescale_rst(i_prescale_rst),
        .i_prog(i_prog),
        .o_gate(o_gate),
        .o_load(o_load),
        .o_store_b(o_store_b),
        .o_seg(o_seg),
        .o_digit_en(o_digit_en)
    );

    osc_display_model #(
        .XTAL_HALF_NS(XTAL_CLKS * 10)
    ) osc_display_model_inst (
        .i_mclk(i_mclk),
        .i_slow(slow),
        .o_osc(osc),
        .o_xtal_ref(xtal),
        .i_seg(o_seg),
        .i_digit_en(o_digit_en),
        .o_shown(shown)
    );

    //==========
    // Helpers
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        num_checks++;
        if (seen !== want) begin
            bad_count++;
            $display("[FAIL] t=%0t seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic print_verdict();
        if (bad_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Returns at the first falling clock edge after the transfer pulse starts.
    task automatic wait_fall();
        bit hi;
        hi = 1'b0;
        for (int n = 0; n < 3000; n++) begin
            @(negedge i_mclk);
            if (o_store_b === 1'b1) begin
                hi = 1'b1;
            end else if (hi) begin
                return;
            end
        end
        bad_count++;
        print_verdict();
    endtask

    task automatic check_timing();
        int n_store;
        int n_load;
        int n_gate;
        n_store = 0;
        n_load = 0;
        n_gate = 0;
        wait_fall();
        check(32'(o_load), 32'h1);
        check(32'(o_gate), 32'h0);
        for (int n = 0; n < 2 * HALF; n++) begin
            n_store += (o_store_b === 1'b0);
            n_load += (o_load === 1'b1);
            n_gate += (o_gate === 1'b1);
            @(negedge i_mclk);
        end
        check(32'(n_store), 32'(STOREC));
        check(32'(n_load), 32'(LOADC));
        check(32'(n_gate), 32'(HALF));
        check(32'(o_store_b), 32'h0);
    endtask

    task automatic check_scan();
        int lit[6];
        int odd;
        logic [5:0] prev;
        odd = 0;
        foreach (lit[d]) lit[d] = 0;
        prev = o_digit_en;
        for (int n = 0; n < 12 * DIGC; n++) begin
            @(negedge i_mclk);
            if (!$onehot(o_digit_en)) begin
                odd++;
            end
            if (o_digit_en !== prev && o_digit_en !== {prev[4:0], prev[5]}) begin
                odd++;
            end
            foreach (lit[d]) lit[d] += (o_digit_en[d] === 1'b1);
            prev = o_digit_en;
        end
        check(32'(odd), 32'h0);
        foreach (lit[d]) check(32'(lit[d]), 32'(2 * DIGC));
    endtask

    //==========
    // Clock and result watcher
    initial begin
        i_mclk = 1'b0;
        forever #10 i_mclk = ~i_mclk;
    end

    // A tick that lands on a gate edge may be dropped, so one count short is accepted.
    always @(negedge o_store_b) begin
        logic [23:0] want;
        logic [23:0] got;
        if (exp_q.size() > 0) begin
            want = exp_q.pop_front();
            repeat (100) @(negedge i_mclk);
            got = (want[3:0] != 4'h0 && shown === want - 24'h000001) ? want : shown;
            check(32'(got), 32'(want));
        end
    end

    //==========
    // Main sequence
    initial begin
        bad_count = 0;
        num_checks = 0;
        rnd = 32'h00015569;
        i_rst_b = 1'b0;
        i_prescale_rst = 1'b0;
        i_prog = 4'h0;
        slow = 1'b0;
        repeat (6) @(negedge i_mclk);
        check(32'({o_gate, o_load, o_store_b}), 32'h5);
        check(32'({o_seg, o_digit_en}), 32'h20);
        i_rst_b = 1'b1;
        check_scan();
        check_timing();
        for (int r = 0; r < 8; r++) begin
            rnd = xorshift(rnd);
            i_prog = (r < 4) ? {r[1], rnd[1:0], r[0]} : rnd[3:0];
            slow = rnd[4];
            i_prescale_rst = (rnd[7:5] == 3'h0) || (r == 2);
            wait_fall();
            exp_q.push_back(((i_prog[0] & i_prog[3]) ? freq_counter_pkg::PRESET_LOW_BANDS
                : freq_counter_pkg::PRESET_OTHER_BANDS)
                + (i_prescale_rst ? 24'h000000 : (slow ? 24'h000008 : 24'h000016)));
            wait_fall();
        end
        repeat (120) @(negedge i_mclk);
        check(32'(exp_q.size()), 32'h0);
        print_verdict();
    end
endmodule
